// ===== eas_area_table.v
`timescale 1ns/1ns
// small per-area table: holds last transfer count per area, registered read
module eas_area_table
(
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       sys_rst_in,
    // write port
    input  wire       wr_en_in,
    input  wire [2:0] wr_idx_in,
    input  wire [7:0] wr_data_in,
    // read port
    input  wire [2:0] rd_idx_in,
    output reg  [7:0] rd_data_out
);
    reg [7:0] mem_q [0:7];
    integer   i;

    // storage and registered read
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (i = 0; i < 8; i = i + 1)
                mem_q[i] <= 8'h00;
            rd_data_out <= 8'h00;
        end
        else
        begin
            if (wr_en_in)
                mem_q[wr_idx_in] <= wr_data_in;
            rd_data_out <= mem_q[rd_idx_in];
        end
    end
endmodule

// ===== eas_ctrl.v
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "eas_map.vh"
module eas_ctrl
(
    // clock and reset
    input  wire        ref_clk_in,
    input  wire        sys_rst_in,
    // operating mode straps
    input  wire        mode_rom_en_in,
    input  wire        mode_bus8_in,
    // register port
    input  wire [3:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // internal bus master request
    input  wire        req_valid_in,
    input  wire [23:0] req_addr_in,
    input  wire        req_write_in,
    input  wire [1:0]  req_size_in,
    input  wire [31:0] req_wdata_in,
    output reg         req_ready_out,
    output reg  [31:0] req_rdata_out,
    output reg         req_internal_out,
    // external memory pins
    input  wire        wait_n_in,
    input  wire [15:0] ext_data_in,
    output reg  [15:0] ext_data_out,
    output reg         ext_data_hi_oe_out,
    output reg         ext_data_lo_oe_out,
    output reg  [23:0] ext_addr_out,
    output reg         read_strobe_n_out,
    output reg         upper_write_strobe_n_out,
    output reg         lower_write_strobe_n_out,
    output reg  [7:0]  area_select_n_out,
    output reg  [7:0]  area_select_oe_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_T1   = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_T3   = 2'h3;

    reg  [7:0]  mode_q, width_q, astate_q, waith_q, waitl_q;
    reg  [7:0]  sysctl_q, pincfg_q, dir_q;
    reg  [1:0]  st_q;
    reg  [2:0]  cnt_q;
    reg  [2:0]  area_q;
    reg  [23:0] addr_q;
    reg  [1:0]  left_q;
    reg  [31:0] wdat_q;
    reg  [31:0] rdat_q;
    reg         write_q, wide_q;
    reg         strap_q;
    reg  [1:0]  wsync_q;
    reg  [15:0] dsync1_q, dsync2_q;

    // bus cycles needed after the first for a transfer
    function [1:0] xfer_count;
        input [1:0] size;
        input       wide;
        begin
            case (size)
                `EAS_SZ_BYTE: xfer_count = 2'h0;
                `EAS_SZ_WORD: xfer_count = wide ? 2'h0 : 2'h1;
                default:      xfer_count = wide ? 2'h1 : 2'h3;
            endcase
        end
    endfunction

    wire [2:0] req_area = req_addr_in[23:21];
    wire area_wide = ~width_q[req_area] |
        (req_area == 3'h0 && mode_q[`EAS_MODE_BURST]);
    wire int_rom = req_area == 3'h0 && mode_rom_en_in &&
        req_addr_in < `EAS_ROM_TOP;
    wire int_ram = req_area == 3'h7 && sysctl_q[`EAS_SYS_RAM_EN] &&
        req_addr_in >= `EAS_RAM_BASE && req_addr_in < `EAS_IO_BASE;
    wire int_io  = req_area == 3'h7 && req_addr_in >= `EAS_IO_BASE;
    wire is_int  = int_rom | int_ram | int_io;
    // wait count, zero for two-state areas
    wire [1:0] wsel = {waith_q[area_q], waitl_q[area_q]};
    wire [2:0] wcnt = astate_q[area_q] ? {1'b0, wsel} : 3'h0;
    reg        word_q;
    // a full word moves only for word or long sizes at an even address
    wire       cyc_word = wide_q & ~addr_q[0] & word_q;
    wire       cyc_hi = ~wide_q | ~addr_q[0];

    // pin enable: direction plus routing bits
    reg [7:0] pin_en;
    always @*
    begin
        pin_en    = dir_q;
        pin_en[1] = dir_q[1] & pincfg_q[`EAS_PIN_S167_EN] &
            pincfg_q[`EAS_PIN_S17_RT];
        pin_en[6] = dir_q[6] & pincfg_q[`EAS_PIN_S167_EN] &
            pincfg_q[`EAS_PIN_S36_RT];
        pin_en[7] = dir_q[7] & pincfg_q[`EAS_PIN_S167_EN] &
            pincfg_q[`EAS_PIN_S17_RT];
        pin_en[2] = dir_q[2] & pincfg_q[`EAS_PIN_S25_EN];
        pin_en[5] = dir_q[5] & pincfg_q[`EAS_PIN_S25_EN] &
            pincfg_q[`EAS_PIN_PF1_S5];
        pin_en[3] = dir_q[3] & pincfg_q[`EAS_PIN_S36_RT];
        pin_en[4] = dir_q[4] & pincfg_q[`EAS_PIN_PF0_S4];
    end

    // strap capture after reset release; a strap cannot meet async reset
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            strap_q <= 1'b0;
        else
            strap_q <= 1'b1;
    end

    // register writes
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            mode_q   <= 8'h00;
            width_q  <= 8'h00;
            astate_q <= `EAS_RST_ASTATE;
            waith_q  <= `EAS_RST_WAIT;
            waitl_q  <= `EAS_RST_WAIT;
            sysctl_q <= `EAS_RST_SYSCTL;
            pincfg_q <= `EAS_RST_PINCFG;
            dir_q    <= 8'h00;
        end
        else if (!strap_q)
        begin
            width_q <= mode_bus8_in ? 8'hff : 8'h00;
            dir_q   <= mode_rom_en_in ? 8'h00 : 8'h01;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                // only area 0 burst bit kept
                `EAS_REG_MODE:   mode_q   <= {7'h00,
                    reg_wdata_in[`EAS_MODE_BURST]};
                `EAS_REG_WIDTH:  width_q  <= reg_wdata_in;
                `EAS_REG_ASTATE: astate_q <= reg_wdata_in;
                `EAS_REG_WAITH:  waith_q  <= reg_wdata_in;
                `EAS_REG_WAITL:  waitl_q  <= reg_wdata_in;
                `EAS_REG_SYSCTL: sysctl_q <= reg_wdata_in;
                `EAS_REG_PINCFG: pincfg_q <= reg_wdata_in;
                `EAS_REG_DIR:    dir_q    <= reg_wdata_in;
                default:         ;
            endcase
        end
    end

    // register reads, one cycle later; unmapped reads zero
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `EAS_REG_MODE:   reg_rdata_out <= mode_q;
                `EAS_REG_WIDTH:  reg_rdata_out <= width_q;
                `EAS_REG_ASTATE: reg_rdata_out <= astate_q;
                `EAS_REG_WAITH:  reg_rdata_out <= waith_q;
                `EAS_REG_WAITL:  reg_rdata_out <= waitl_q;
                `EAS_REG_SYSCTL: reg_rdata_out <= sysctl_q;
                `EAS_REG_PINCFG: reg_rdata_out <= pincfg_q;
                `EAS_REG_DIR:    reg_rdata_out <= dir_q;
                `EAS_REG_STATUS: reg_rdata_out <= {3'h0, area_q,
                    st_q != ST_IDLE, strap_q};
                default:         reg_rdata_out <= 8'h00;
            endcase
        end
        else
            reg_rdata_out <= 8'h00;
    end

    // pin synchronisers; first stage feeds only the second
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wsync_q  <= 2'h3;
            dsync1_q <= 16'h0000;
            dsync2_q <= 16'h0000;
        end
        else
        begin
            wsync_q  <= {wsync_q[0], wait_n_in};
            dsync1_q <= ext_data_in;
            dsync2_q <= dsync1_q;
        end
    end

    // bus cycle state machine
    always @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            area_q <= 3'h0;
            addr_q <= 24'h000000;
            left_q <= 2'h0;
            wdat_q <= 32'h00000000;
            rdat_q <= 32'h00000000;
            write_q <= 1'b0;
            wide_q <= 1'b0;
            word_q <= 1'b0;
            req_ready_out <= 1'b0;
            req_rdata_out <= 32'h00000000;
            req_internal_out <= 1'b0;
            ext_data_out <= 16'h0000;
            ext_data_hi_oe_out <= 1'b0;
            ext_data_lo_oe_out <= 1'b0;
            ext_addr_out <= 24'h000000;
            read_strobe_n_out <= 1'b1;
            upper_write_strobe_n_out <= 1'b1;
            lower_write_strobe_n_out <= 1'b1;
            area_select_n_out <= 8'hff;
            area_select_oe_out <= 8'h00;
        end
        else
        begin
            req_ready_out <= 1'b0;
            req_internal_out <= 1'b0;
            area_select_oe_out <= pin_en;
            case (st_q)
                ST_IDLE:
                begin
                    area_select_n_out <= 8'hff;
                    read_strobe_n_out <= 1'b1;
                    upper_write_strobe_n_out <= 1'b1;
                    lower_write_strobe_n_out <= 1'b1;
                    ext_data_hi_oe_out <= 1'b0;
                    ext_data_lo_oe_out <= 1'b0;
                    // a request still standing beside ready is the old one
                    if (req_valid_in && !req_ready_out && is_int)
                    begin
                        // internal access: no select, answered at once
                        req_ready_out <= 1'b1;
                        req_internal_out <= 1'b1;
                    end
                    else if (req_valid_in && !req_ready_out)
                    begin
                        area_q <= req_area;
                        addr_q <= req_addr_in;
                        wide_q <= area_wide;
                        word_q <= req_size_in != `EAS_SZ_BYTE;
                        write_q <= req_write_in;
                        left_q <= xfer_count(req_size_in, area_wide);
                        // left-align so the first unit sits in the top bits
                        if (req_size_in == `EAS_SZ_BYTE)
                            wdat_q <= {req_wdata_in[7:0], 24'h000000};
                        else if (req_size_in == `EAS_SZ_WORD)
                            wdat_q <= {req_wdata_in[15:0], 16'h0000};
                        else
                            wdat_q <= req_wdata_in;
                        rdat_q <= 32'h00000000;
                        st_q <= ST_T1;
                    end
                end
                ST_T1:
                begin
                    ext_addr_out <= addr_q;
                    area_select_n_out <= ~(8'h01 << area_q);
                    read_strobe_n_out <= write_q;
                    upper_write_strobe_n_out <= ~(write_q & cyc_hi);
                    lower_write_strobe_n_out <= ~(write_q & wide_q &
                        (addr_q[0] | cyc_word));
                    // undriven halves float; reads stay input
                    ext_data_hi_oe_out <= write_q & cyc_hi;
                    ext_data_lo_oe_out <= write_q & wide_q &
                        (addr_q[0] | cyc_word);
                    if (cyc_word)
                        ext_data_out <= wdat_q[31:16];
                    else
                        ext_data_out <= {wdat_q[31:24], wdat_q[31:24]};
                    cnt_q <= wcnt;
                    st_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (cnt_q != 3'h0)
                        cnt_q <= cnt_q - 3'h1;
                    else if (wsync_q[1] || !astate_q[area_q])
                        st_q <= ST_T3;
                end
                ST_T3:
                begin
                    read_strobe_n_out <= 1'b1;
                    upper_write_strobe_n_out <= 1'b1;
                    lower_write_strobe_n_out <= 1'b1;
                    area_select_n_out <= 8'hff;
                    ext_data_hi_oe_out <= 1'b0;
                    ext_data_lo_oe_out <= 1'b0;
                    if (cyc_word)
                    begin
                        rdat_q <= {rdat_q[15:0], dsync2_q};
                        wdat_q <= {wdat_q[15:0], 16'h0000};
                    end
                    else
                    begin
                        rdat_q <= {rdat_q[23:0], addr_q[0] & wide_q ?
                            dsync2_q[7:0] : dsync2_q[15:8]};
                        wdat_q <= {wdat_q[23:0], 8'h00};
                    end
                    if (left_q == 2'h0)
                    begin
                        req_ready_out <= 1'b1;
                        st_q <= ST_IDLE;
                        if (cyc_word)
                            req_rdata_out <= {rdat_q[15:0], dsync2_q};
                        else
                            req_rdata_out <= {rdat_q[23:0],
                                addr_q[0] & wide_q ? dsync2_q[7:0] :
                                dsync2_q[15:8]};
                    end
                    else
                    begin
                        left_q <= left_q - 2'h1;
                        addr_q <= addr_q + ((wide_q && !addr_q[0]) ?
                            24'h000002 : 24'h000001);
                        st_q <= ST_T1;
                    end
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // per-area record of left_q at the last external ready, visible to nothing else yet
    eas_area_table u_table
    (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (req_ready_out & ~req_internal_out),
        .wr_idx_in   (area_q),
        .wr_data_in  ({6'h00, left_q}),
        .rd_idx_in   (area_q),
        .rd_data_out ()
    );
endmodule

// ===== eas_ctrl_bench.sv
`timescale 1ns/1ns
`include "eas_map.vh"
`define CHK(got, exp) \
    begin \
        num_checks = num_checks + 1; \
        if ((got) !== (exp)) \
        begin \
            bad_count = bad_count + 1; \
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp); \
        end \
    end
module eas_ctrl_bench;
    localparam [1:0] BY = `EAS_SZ_BYTE;
    localparam [1:0] WD = `EAS_SZ_WORD;
    localparam [1:0] LG = `EAS_SZ_LONG;
    reg         ref_clk_in, sys_rst_in, mode_rom_en_in, mode_bus8_in;
    reg  [3:0]  reg_addr_in;
    reg  [7:0]  reg_wdata_in;
    reg         reg_wr_in, reg_rd_in, req_valid_in, req_write_in, slow;
    reg  [23:0] req_addr_in;
    reg  [1:0]  req_size_in;
    reg  [31:0] req_wdata_in;
    reg  [3:0]  n_rd, n_hi, n_lo;
    integer     bad_count, num_checks;
    wire [7:0]  reg_rdata_out, area_select_n_out, area_select_oe_out;
    wire [31:0] req_rdata_out;
    wire [23:0] ext_addr_out;
    wire [15:0] ext_data_out, drv;
    wire        req_ready_out, req_internal_out, wait_n_in;
    wire        ext_data_hi_oe_out, ext_data_lo_oe_out, read_strobe_n_out;
    wire        upper_write_strobe_n_out, lower_write_strobe_n_out;
    // each lane shows whoever drives it
    wire [15:0] ext_data_in = {
        ext_data_hi_oe_out ? ext_data_out[15:8] : drv[15:8],
        ext_data_lo_oe_out ? ext_data_out[7:0] : drv[7:0]};

    eas_ctrl i_dut (.ref_clk_in, .sys_rst_in, .mode_rom_en_in, .mode_bus8_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .req_valid_in, .req_addr_in, .req_write_in, .req_size_in,
        .req_wdata_in, .req_ready_out, .req_rdata_out, .req_internal_out,
        .wait_n_in, .ext_data_in, .ext_data_out, .ext_data_hi_oe_out,
        .ext_data_lo_oe_out, .ext_addr_out, .read_strobe_n_out,
        .upper_write_strobe_n_out, .lower_write_strobe_n_out,
        .area_select_n_out, .area_select_oe_out);

    eas_mem_model i_mem (.ref_clk_in(ref_clk_in), .slow_in(slow),
        .addr_in(ext_addr_out), .rd_n_in(read_strobe_n_out),
        .hw_n_in(upper_write_strobe_n_out),
        .lw_n_in(lower_write_strobe_n_out), .sel_n_in(area_select_n_out),
        .bus_in(ext_data_in), .drive_out(drv), .wait_n_out(wait_n_in));

    // 50 MHz clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // strobe pulse counters, cleared at each transfer
    always @(negedge read_strobe_n_out) n_rd = n_rd + 4'h1;
    always @(negedge upper_write_strobe_n_out) n_hi = n_hi + 4'h1;
    always @(negedge lower_write_strobe_n_out) n_lo = n_lo + 4'h1;

    task give_verdict;
        begin
            if (bad_count == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task reg_wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk_in);
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_wr_in <= 1'b1;
            @(posedge ref_clk_in);
            reg_wr_in <= 1'b0;
        end
    endtask

    // read data stands only in the cycle after the strobe
    task reg_rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge ref_clk_in);
            reg_addr_in <= a;
            reg_rd_in <= 1'b1;
            @(posedge ref_clk_in);
            reg_rd_in <= 1'b0;
            #1;
            `CHK(reg_rdata_out, exp)
        end
    endtask

    // one request; cnt packs expected read, upper, lower strobe counts
    task xf(input [23:0] a, input w, input [1:0] sz, input [31:0] d,
            input [11:0] cnt, input intl);
        integer     k;
        reg  [31:0] got;
        reg         in_seen;
        begin
            n_rd = 4'h0;
            n_hi = 4'h0;
            n_lo = 4'h0;
            @(posedge ref_clk_in);
            req_valid_in <= 1'b1;
            req_addr_in <= a;
            req_write_in <= w;
            req_size_in <= sz;
            req_wdata_in <= d;
            k = 0;
            while (req_ready_out !== 1'b1 && k < 400)
            begin
                @(posedge ref_clk_in);
                #1;
                k = k + 1;
            end
            if (k == 400)
            begin
                bad_count = bad_count + 1;
                give_verdict;
            end
            got = req_rdata_out;
            in_seen = req_internal_out;
            @(posedge ref_clk_in);
            req_valid_in <= 1'b0;
            `CHK({n_rd, n_hi, n_lo}, cnt)
            `CHK(in_seen, intl)
            if (!w && !intl)
                `CHK(got & (sz == BY ? 32'hff : sz == WD ? 32'hffff :
                    ~32'h0), d)
        end
    endtask

    initial
    begin
        bad_count = 0;
        num_checks = 0;
        {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = 14'h0;
        {req_valid_in, req_addr_in, req_write_in, req_size_in} = 28'h0;
        req_wdata_in = 32'h0;
        slow = 1'b0;
        mode_rom_en_in = 1'b0;
        mode_bus8_in = 1'b1;
        sys_rst_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(area_select_oe_out, 8'h01)
        `CHK(area_select_n_out, 8'hff)
        reg_rd(`EAS_REG_ASTATE, `EAS_RST_ASTATE);
        reg_rd(`EAS_REG_WAITL, `EAS_RST_WAIT);
        reg_rd(`EAS_REG_WIDTH, 8'hff);
        reg_rd(`EAS_REG_SYSCTL, `EAS_RST_SYSCTL);
        reg_rd(4'hf, 8'h00);
        reg_wr(`EAS_REG_WIDTH, 8'h01);
        reg_rd(`EAS_REG_WIDTH, 8'h01);
        xf(24'h000010, 1'b1, LG, 32'h11223344, 12'h040, 1'b0);
        xf(24'h000010, 1'b0, LG, 32'h11223344, 12'h400, 1'b0);
        xf(24'h200020, 1'b1, LG, 32'haabbccdd, 12'h022, 1'b0);
        xf(24'h200022, 1'b0, WD, 32'h0000ccdd, 12'h100, 1'b0);
        xf(24'h200021, 1'b0, BY, 32'h000000bb, 12'h100, 1'b0);
        xf(24'h200024, 1'b1, BY, 32'h0000005a, 12'h010, 1'b0);
        xf(24'h200025, 1'b1, BY, 32'h000000a5, 12'h001, 1'b0);
        slow = 1'b1;
        xf(24'h200024, 1'b0, WD, 32'h00005aa5, 12'h100, 1'b0);
        slow = 1'b0;
        xf(24'hffb000, 1'b1, BY, 32'h00000077, 12'h000, 1'b1);
        reg_wr(`EAS_REG_SYSCTL, 8'h00);
        xf(24'hffb030, 1'b1, WD, 32'h00001234, 12'h011, 1'b0);
        xf(24'hffb030, 1'b0, WD, 32'h00001234, 12'h100, 1'b0);
        xf(24'hffff00, 1'b1, BY, 32'h00000011, 12'h000, 1'b1);
        // second reset with on-chip rom enabled
        mode_rom_en_in <= 1'b1;
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(area_select_oe_out, 8'h00)
        xf(24'h000100, 1'b0, BY, 32'h00000000, 12'h000, 1'b1);
        xf(24'h010040, 1'b0, BY, 32'h00000040, 12'h100, 1'b0);
        `CHK(area_select_oe_out, 8'h00)
        give_verdict;
    end
endmodule

// ===== eas_ctrl_properties.sv
`timescale 1ns/1ns
// pin-level watcher for strobes, data lanes and area selects
module eas_ctrl_chk
(
    // clock and reset
    input wire        ref_clk_in,
    input wire        sys_rst_in,
    // request side
    input wire        req_ready_out,
    input wire        req_internal_out,
    // memory pins
    input wire        ext_data_hi_oe_out,
    input wire        ext_data_lo_oe_out,
    input wire [23:0] ext_addr_out,
    input wire        read_strobe_n_out,
    input wire        upper_write_strobe_n_out,
    input wire        lower_write_strobe_n_out,
    input wire [7:0]  area_select_n_out
);
    // any low strobe marks an external cycle in progress
    wire rd_on  = !read_strobe_n_out;
    wire hi_on  = !upper_write_strobe_n_out;
    wire lo_on  = !lower_write_strobe_n_out;
    wire bus_on = rd_on || hi_on || lo_on;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_read_no_write: assert property (rd_on |->
        !hi_on && !lo_on)
        else $error("write strobe low during read");
    chk_read_lanes_in: assert property (rd_on |->
        !ext_data_hi_oe_out && !ext_data_lo_oe_out)
        else $error("data lane driven during read");
    chk_upper_lane_drive: assert property (hi_on |->
        ext_data_hi_oe_out)
        else $error("upper strobe without upper drive");
    chk_lower_lane_drive: assert property (lo_on |->
        ext_data_lo_oe_out)
        else $error("lower strobe without lower drive");
    chk_lower_lane_float: assert property (hi_on && !lo_on |->
        !ext_data_lo_oe_out)
        else $error("lower lane not floating");
    chk_upper_lane_float: assert property (lo_on && !hi_on |->
        !ext_data_hi_oe_out)
        else $error("upper lane not floating");
    chk_select_area: assert property (bus_on |->
        !area_select_n_out[ext_addr_out[23:21]])
        else $error("select of addressed area not low");
    chk_select_single: assert property (bus_on |->
        $onehot(~area_select_n_out))
        else $error("not exactly one select low");
    chk_internal_quiet: assert property (req_internal_out |->
        &area_select_n_out && read_strobe_n_out)
        else $error("select or strobe on internal access");
    chk_ready_one_cycle: assert property (req_ready_out |=> !req_ready_out)
        else $error("ready longer than one cycle");
    chk_read_bounded: assert property ($fell(read_strobe_n_out) |->
        ##[1:80] read_strobe_n_out)
        else $error("read strobe stuck low");
    chk_reset_idle: assert property ($fell(sys_rst_in) |->
        &area_select_n_out && !bus_on)
        else $error("pins not idle after reset");

    // main scenarios
    cov_read: cover property (rd_on);
    cov_word_write: cover property (hi_on && lo_on);
    cov_odd_byte: cover property (lo_on && !hi_on);
    cov_internal: cover property (req_internal_out);
endmodule

bind eas_ctrl eas_ctrl_chk i_chk (.ref_clk_in, .sys_rst_in, .req_ready_out,
    .req_internal_out, .ext_data_hi_oe_out, .ext_data_lo_oe_out,
    .ext_addr_out, .read_strobe_n_out, .upper_write_strobe_n_out,
    .lower_write_strobe_n_out, .area_select_n_out);

// ===== eas_map.vh
`ifndef EAS_MAP_VH
`define EAS_MAP_VH
// register indices on the plain register port
`define EAS_REG_MODE      4'h0
`define EAS_REG_WIDTH     4'h1
`define EAS_REG_ASTATE    4'h2
`define EAS_REG_WAITH     4'h3
`define EAS_REG_WAITL     4'h4
`define EAS_REG_SYSCTL    4'h5
`define EAS_REG_PINCFG    4'h6
`define EAS_REG_DIR       4'h7
`define EAS_REG_STATUS    4'h8
// reset values
`define EAS_RST_ASTATE    8'hff
`define EAS_RST_WAIT      8'hff
`define EAS_RST_SYSCTL    8'h01
`define EAS_RST_PINCFG    8'h00
// mode register fields
`define EAS_MODE_BURST    0
// system control fields
`define EAS_SYS_RAM_EN    0
// pin configuration fields
`define EAS_PIN_S167_EN   0
`define EAS_PIN_S25_EN    1
`define EAS_PIN_S17_RT    2
`define EAS_PIN_S36_RT    3
`define EAS_PIN_PF1_S5    4
`define EAS_PIN_PF0_S4    5
// access sizes
`define EAS_SZ_BYTE       2'h0
`define EAS_SZ_WORD       2'h1
`define EAS_SZ_LONG       2'h2
// address map: area is addr[23:21]
`define EAS_ROM_TOP       24'h010000
`define EAS_RAM_BASE      24'hffb000
`define EAS_IO_BASE       24'hffff00
// cycle timing
`define EAS_T2_STATES     3'h1
`define EAS_T3_STATES     3'h2
`endif

// ===== eas_mem_model.sv
`timescale 1ns/1ns
// byte-addressed memory on the far side; area 0 is an 8-bit part
module eas_mem_model
(
    // clock and stall mode
    input  wire        ref_clk_in,
    input  wire        slow_in,
    // memory pins
    input  wire [23:0] addr_in,
    input  wire        rd_n_in,
    input  wire        hw_n_in,
    input  wire        lw_n_in,
    input  wire [7:0]  sel_n_in,
    input  wire [15:0] bus_in,
    output reg  [15:0] drive_out,
    output reg         wait_n_out
);
    reg  [7:0]  mem [0:255];
    reg  [15:0] last_q;
    reg  [2:0]  stall_q;
    integer     i;
    wire        sel    = ~&sel_n_in;
    wire [7:0]  ev     = {addr_in[7:1], 1'b0};
    // 8-bit part sits on upper lane
    wire [7:0]  hi_idx = !sel_n_in[0] ? addr_in[7:0] : ev;

    // known contents so reads of unwritten places still check
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0];
        last_q = 16'h0000;
        stall_q = 3'h0;
        wait_n_out = 1'b1;
    end

    // released bus shows inverse of last value, never a stale match
    always @*
        if (sel && !rd_n_in)
            drive_out = {mem[hi_idx], mem[ev | 8'h01]};
        else
            drive_out = ~last_q;

    // writes per lane strobe, plus optional wait stall
    always @(posedge ref_clk_in)
    begin
        if (sel && !rd_n_in)
            last_q <= drive_out;
        if (sel && !hw_n_in)
            mem[hi_idx] <= bus_in[15:8];
        if (sel && !lw_n_in)
            mem[ev | 8'h01] <= bus_in[7:0];
        stall_q <= sel ? ((stall_q == 3'h7) ? stall_q : stall_q + 3'h1) :
            3'h0;
        wait_n_out <= !(slow_in && sel && stall_q < 3'h4);
    end
endmodule
